/* gpib_card_consts.svh */
/*
 Constants of the option card link: register offsets, field positions,
 reset values, bus line positions and timing counts.
 Assumes it is included by its bare name, after the timescale line.
*/
`ifndef GPIB_CARD_CONSTS_SVH
`define GPIB_CARD_CONSTS_SVH

// ----------------------------------------
// Register offsets (three host address bits)
// ----------------------------------------
`define REG_CTRL_STAT   3'h0
`define REG_DATA        3'h1
`define REG_AUX         3'h2
`define REG_POLL        3'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_TALK       0
`define CTRL_SRQ        1
`define CTRL_REMOTE     2
`define CTRL_IRQ_EN     3
`define STAT_REMOTE     0
`define STAT_RX_FULL    1
`define STAT_TX_DONE    2
`define STAT_TALK       3
`define STAT_SRQ        4
`define AUX_END         0
`define CTRL_RESET      4'h0
`define POLL_RESET      8'h00

// ----------------------------------------
// Management line positions in the control line vector
// ----------------------------------------
`define LN_DAV          0
`define LN_NRFD         1
`define LN_NDAC         2
`define LN_EOI          3
`define LN_ATN          4
`define LN_SRQ          5
`define LN_IFC          6
`define LN_REN          7
`define CMD_POLL_ENABLE 8'h18

// ----------------------------------------
// Timing: host clock out, init sequence, strobe widths
// ----------------------------------------
`define SYS_CLK_HZ      20000000
`define CARD_CLK_HZ     1228800
`define CARD_HALF_CYC   (`SYS_CLK_HZ / (2 * `CARD_CLK_HZ))
`define INIT_WRITES     6
`define WR_LOW_CYC      2
`define RD_CYC          2

`endif

/* gpib_card_pkg.sv */
/*
 Types shared by both ends of the option card link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package gpib_card_pkg;

	// Card side bus handshake states
	typedef enum logic [3:0] {
		HS_IDLE   = 4'b0001,
		HS_LACPT  = 4'b0010,
		HS_TSETUP = 4'b0100,
		HS_TVALID = 4'b1000
	} hsState_t;

	// Host side access states
	typedef enum logic [4:0] {
		HO_INIT  = 5'b00001,
		HO_IDLE  = 5'b00010,
		HO_WLOW  = 5'b00100,
		HO_WHIGH = 5'b01000,
		HO_READ  = 5'b10000
	} hostState_t;

endpackage

/* gpib_card_if.sv */
/*
 Host microprocessor bus between the instrument host and the option card.
 Assumes both ends run on the same system clock; resolves the shared data
 bus and the pulled-up open-drain interrupt line.
*/
`timescale 1ns/1ps
`default_nettype none

interface gpib_card_if;
	// ----------------------------------------
	// Host driven
	// ----------------------------------------
	logic [2:0] addr;
	logic [7:0] hostData;
	logic       chipSelectN;
	logic       readDataDrive;
	logic       writeStrobeN;
	logic       cardClock;
	// ----------------------------------------
	// Card driven
	// ----------------------------------------
	logic [7:0] cardData;
	logic       cardDataOeN;
	logic       irqOut;
	logic       irqOeN;
	logic       optionPresentN;
	// ----------------------------------------
	// Resolved wires
	// ----------------------------------------
	logic [7:0] readBus;
	logic       hostInterruptN;

	// Pull-up on the interrupt line, released data bus reads high
	assign hostInterruptN = irqOeN ? 1'b1 : irqOut;
	assign readBus        = cardDataOeN ? 8'hff : cardData;

	modport card (input addr, hostData, chipSelectN, readDataDrive, writeStrobeN, cardClock,
		output cardData, cardDataOeN, irqOut, irqOeN, optionPresentN);
	modport host (output addr, hostData, chipSelectN, readDataDrive, writeStrobeN, cardClock,
		input readBus, hostInterruptN, optionPresentN);
endinterface

`default_nettype wire

/* gpib_card_device.sv */
/*
 Option card end: four byte registers for the host, per character
 interrupt, and the instrument bus handshake with transceiver directions.
 Assumes the host end of gpib_card_if on the same clk_sys, and instrument
 bus lines arriving asynchronously as level (low = true) inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpib_card_consts.svh"

module gpib_card_device
	import gpib_card_pkg::*;
(
	// Clock and reset
	input  wire logic  clk_sys,
	input  wire logic  resetn,
	// Host bus
	gpib_card_if.card  hostBus,
	// Instrument bus data lines
	input  wire logic [7:0] dioIn,
	output logic      [7:0] dioOut,
	output logic      [7:0] dioOeN,
	// Instrument bus management lines
	input  wire logic [7:0] ctlIn,
	output logic      [7:0] ctlOut,
	output logic      [7:0] ctlOeN,
	// Transceiver direction and status
	output logic            talkerDirectionSelect,
	output logic            controllerInCharge,
	output logic            remoteStateOut
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [7:0] dioMeta, dioSync, ctlMeta, ctlSync;

	// Bus pins are asynchronous: two flops before any use
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dioMeta <= 8'hff;
			dioSync <= 8'hff;
			ctlMeta <= 8'hff;
			ctlSync <= 8'hff;
		end else begin
			dioMeta <= dioIn;
			dioSync <= dioMeta;
			ctlMeta <= ctlIn;
			ctlSync <= ctlMeta;
		end
	end

	logic atnTrue, davTrue, nrfdHigh, ndacHigh, ifcTrue;
	assign atnTrue  = ~ctlSync[`LN_ATN];
	assign davTrue  = ~ctlSync[`LN_DAV];
	assign nrfdHigh = ctlSync[`LN_NRFD];
	assign ndacHigh = ctlSync[`LN_NDAC];
	assign ifcTrue  = ~ctlSync[`LN_IFC];

	// ----------------------------------------
	// Host strobes and card clock edges
	// ----------------------------------------
	logic wrPrev, rdPrev, clkPrev;
	logic wrEvent, rdEvent, tick, reading;

	// Same clock as the host logic, so no synchroniser is needed here
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wrPrev  <= 1'b1;
			rdPrev  <= 1'b0;
			clkPrev <= 1'b0;
		end else begin
			wrPrev  <= hostBus.writeStrobeN;
			rdPrev  <= reading;
			clkPrev <= hostBus.cardClock;
		end
	end

	assign reading = ~hostBus.chipSelectN & hostBus.readDataDrive;
	assign wrEvent = ~wrPrev & hostBus.writeStrobeN & ~hostBus.chipSelectN;
	assign rdEvent = reading & ~rdPrev;
	assign tick    = hostBus.cardClock & ~clkPrev;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [3:0] ctrl_reg;
	logic [7:0] poll_reg, txData_reg, rxData_reg;
	logic       txEnd_reg, txFull_reg, txDone_reg, rxFull_reg;
	logic       byteTaken, txFinished, pollSeen;
	hsState_t   hs_reg;

	// Host writes; bus events clear alongside
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg   <= `CTRL_RESET;
			poll_reg   <= `POLL_RESET;
			txData_reg <= 8'h00;
			txEnd_reg  <= 1'b0;
		end else begin
			// End flag covers one byte only; a host write in the same cycle wins
			if (txFinished)
				txEnd_reg <= 1'b0;
			if (wrEvent) begin
				case (hostBus.addr)
					`REG_CTRL_STAT: ctrl_reg <= hostBus.hostData[3:0];
					`REG_DATA:      txData_reg <= hostBus.hostData;
					`REG_AUX:       txEnd_reg <= hostBus.hostData[`AUX_END];
					`REG_POLL:      poll_reg <= hostBus.hostData;
					default: ;
				endcase
			end
			// A poll from the controller withdraws the request
			if (pollSeen)
				ctrl_reg[`CTRL_SRQ] <= 1'b0;
			// Bus reset drops the talk address
			if (ifcTrue)
				ctrl_reg[`CTRL_TALK] <= 1'b0;
		end
	end

	// Transfer flags: a bus event in the same cycle as the host clear wins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			txFull_reg <= 1'b0;
			txDone_reg <= 1'b0;
			rxFull_reg <= 1'b0;
		end else begin
			// A fresh host byte must not be lost to the finish of the old one
			if (txFinished)
				txFull_reg <= 1'b0;
			if (wrEvent && hostBus.addr == `REG_DATA) begin
				txFull_reg <= 1'b1;
				txDone_reg <= 1'b0;
			end
			if (rdEvent && hostBus.addr == `REG_DATA)
				rxFull_reg <= 1'b0;
			if (txFinished)
				txDone_reg <= 1'b1;
			if (byteTaken && !atnTrue)
				rxFull_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Instrument bus handshake, stepped on the card clock
	// ----------------------------------------
	logic ready;
	assign ready      = ~rxFull_reg | atnTrue;
	assign byteTaken  = tick & (hs_reg == HS_IDLE) & ~talkerDirectionSelect & davTrue & ready;
	assign txFinished = tick & (hs_reg == HS_TVALID) & ndacHigh;
	assign pollSeen   = byteTaken & atnTrue & (~dioSync == `CMD_POLL_ENABLE);

	// Runs each character alone; as talker, once the host has loaded it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hs_reg     <= HS_IDLE;
			rxData_reg <= 8'h00;
		end else if (tick) begin
			case (hs_reg)
				HS_IDLE: begin
					if (byteTaken) begin
						if (!atnTrue)
							rxData_reg <= ~dioSync;
						hs_reg <= HS_LACPT;
					end else if (talkerDirectionSelect && txFull_reg && nrfdHigh && !ndacHigh)
						hs_reg <= HS_TSETUP;
				end
				HS_LACPT: begin
					if (!davTrue)
						hs_reg <= HS_IDLE;
				end
				HS_TSETUP: begin
					hs_reg <= talkerDirectionSelect ? HS_TVALID : HS_IDLE;
				end
				HS_TVALID: begin
					if (ndacHigh || !talkerDirectionSelect)
						hs_reg <= HS_IDLE;
				end
				default: hs_reg <= HS_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Direction control and line levels (low = true on the wire)
	// ----------------------------------------
	logic [7:0] ctlTx;
	logic       lastByte;

	// Talk select follows the talk address; reset value keeps listener
	assign talkerDirectionSelect = ctrl_reg[`CTRL_TALK];
	assign controllerInCharge    = 1'b1;
	assign remoteStateOut        = ctrl_reg[`CTRL_REMOTE];
	assign lastByte              = (hs_reg == HS_TVALID) & txEnd_reg;

	// Transmit enable per management line
	always_comb begin
		ctlTx              = 8'h00;
		ctlTx[`LN_SRQ]     = 1'b1;
		ctlTx[`LN_DAV]     = talkerDirectionSelect;
		ctlTx[`LN_NRFD]    = ~talkerDirectionSelect;
		ctlTx[`LN_NDAC]    = ~talkerDirectionSelect;
		ctlTx[`LN_EOI]     = talkerDirectionSelect & ~atnTrue;
	end

	// Output enables are low while the transceiver transmits
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : gDir
			assign dioOeN[i] = ~talkerDirectionSelect;
			assign ctlOeN[i] = ~ctlTx[i];
		end
	endgenerate

	assign dioOut = ~txData_reg;

	// Line levels; released lines sit high
	always_comb begin
		ctlOut              = 8'hff;
		ctlOut[`LN_DAV]     = ~(hs_reg == HS_TVALID);
		ctlOut[`LN_NRFD]    = ~((hs_reg == HS_LACPT) | ~ready);
		ctlOut[`LN_NDAC]    = ~(hs_reg != HS_LACPT);
		ctlOut[`LN_EOI]     = ~lastByte;
		ctlOut[`LN_SRQ]     = ~ctrl_reg[`CTRL_SRQ];
	end

	// ----------------------------------------
	// Host read data and interrupt
	// ----------------------------------------
	logic [7:0] readData_reg;
	logic       driving_reg;
	logic [7:0] statusByte;

	assign statusByte = {3'h0, ctrl_reg[`CTRL_SRQ], talkerDirectionSelect,
		txDone_reg, rxFull_reg, ctrl_reg[`CTRL_REMOTE]};

	// Read data is registered; the bus is driven one cycle into the read
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			readData_reg <= 8'h00;
			driving_reg  <= 1'b0;
		end else begin
			driving_reg <= reading;
			case (hostBus.addr)
				`REG_CTRL_STAT: readData_reg <= statusByte;
				`REG_DATA:      readData_reg <= rxData_reg;
				`REG_AUX:       readData_reg <= {6'h00, txFull_reg, txEnd_reg};
				`REG_POLL:      readData_reg <= poll_reg;
				default:        readData_reg <= 8'h00;
			endcase
		end
	end

	assign hostBus.cardData       = readData_reg;
	assign hostBus.cardDataOeN    = ~(driving_reg & reading);
	assign hostBus.irqOut         = 1'b0;
	assign hostBus.irqOeN         = ~(ctrl_reg[`CTRL_IRQ_EN] & (rxFull_reg | txDone_reg));
	assign hostBus.optionPresentN = 1'b0;

endmodule

`default_nettype wire

/* gpib_card_host.sv */
/*
 Host end of the option card link: makes the card clock, runs the six
 initialising writes after reset, then serves one access at a time.
 Assumes the card end of gpib_card_if on the same clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpib_card_consts.svh"

module gpib_card_host
	import gpib_card_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Card bus
	gpib_card_if.host       cardBus,
	// Command port
	input  wire logic       cmdValid,
	input  wire logic       cmdWrite,
	input  wire logic [2:0] cmdAddr,
	input  wire logic [7:0] cmdData,
	output logic            cmdReady,
	output logic            rspValid,
	output logic      [7:0] rspData,
	// Status
	output logic            irqPending,
	output logic            cardPresent
);

	// ----------------------------------------
	// Card clock divider
	// ----------------------------------------
	logic [3:0] div_reg;
	logic       cardClk_reg;

	// Square wave near the card rate; 20 MHz does not divide it exactly
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			div_reg     <= 4'h0;
			cardClk_reg <= 1'b0;
		end else if (div_reg == 4'(`CARD_HALF_CYC - 1)) begin
			div_reg     <= 4'h0;
			cardClk_reg <= ~cardClk_reg;
		end else
			div_reg <= div_reg + 4'h1;
	end

	// ----------------------------------------
	// Initialising writes, then interrupt enable and poll byte
	// ----------------------------------------
	function automatic logic [10:0] initStep(input logic [3:0] n);
		case (n)
			4'h0:    initStep = {`REG_CTRL_STAT, 8'h00};
			4'h1:    initStep = {`REG_AUX, 8'h00};
			4'h2:    initStep = {`REG_POLL, 8'h00};
			4'h3:    initStep = {3'h4, 8'h00};
			4'h4:    initStep = {3'h5, 8'h00};
			4'h5:    initStep = {3'h6, 8'h00};
			4'h6:    initStep = {`REG_CTRL_STAT, 8'h08};
			default: initStep = {`REG_POLL, `POLL_RESET};
		endcase
	endfunction

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	hostState_t state_reg, retState_reg;
	logic [3:0] step_reg;
	logic [1:0] cnt_reg;
	logic [2:0] addr_reg;
	logic [7:0] data_reg;

	assign cmdReady = (state_reg == HO_IDLE);

	// Six writes plus two setup writes must finish before any command
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= HO_INIT;
			retState_reg <= HO_INIT;
			step_reg     <= 4'h0;
			cnt_reg      <= 2'h0;
			addr_reg     <= 3'h0;
			data_reg     <= 8'h00;
			rspValid     <= 1'b0;
			rspData      <= 8'h00;
		end else begin
			rspValid <= 1'b0;
			case (state_reg)
				HO_INIT: begin
					if (step_reg == 4'(`INIT_WRITES + 2))
						state_reg <= HO_IDLE;
					else begin
						{addr_reg, data_reg} <= initStep(step_reg);
						step_reg     <= step_reg + 4'h1;
						retState_reg <= HO_INIT;
						cnt_reg      <= 2'h0;
						state_reg    <= HO_WLOW;
					end
				end
				HO_IDLE: begin
					if (cmdValid) begin
						addr_reg     <= cmdAddr;
						data_reg     <= cmdData;
						cnt_reg      <= 2'h0;
						retState_reg <= HO_IDLE;
						state_reg    <= cmdWrite ? HO_WLOW : HO_READ;
					end
				end
				HO_WLOW: begin
					cnt_reg <= cnt_reg + 2'h1;
					if (cnt_reg == 2'(`WR_LOW_CYC - 1))
						state_reg <= HO_WHIGH;
				end
				HO_WHIGH: begin
					rspValid  <= (retState_reg == HO_IDLE);
					state_reg <= retState_reg;
				end
				HO_READ: begin
					cnt_reg <= cnt_reg + 2'h1;
					if (cnt_reg == 2'(`RD_CYC - 1)) begin
						rspData   <= cardBus.readBus;
						rspValid  <= 1'b1;
						state_reg <= HO_IDLE;
					end
				end
				default: state_reg <= HO_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Bus drive
	// ----------------------------------------
	logic active;
	assign active = (state_reg == HO_WLOW) | (state_reg == HO_WHIGH) | (state_reg == HO_READ);

	assign cardBus.cardClock     = cardClk_reg;
	assign cardBus.addr          = addr_reg;
	assign cardBus.hostData      = data_reg;
	assign cardBus.chipSelectN   = ~active;
	assign cardBus.readDataDrive = (state_reg == HO_READ);
	assign cardBus.writeStrobeN  = ~(state_reg == HO_WLOW);

	assign irqPending  = ~cardBus.hostInterruptN;
	assign cardPresent = ~cardBus.optionPresentN;

endmodule

`default_nettype wire

/* gpib_card_link_properties.sv */
/*
 Checker for the option card link: transceiver directions, host read
 answer, interrupt release and reset state of the card end.
 Assumes it is instantiated beside gpib_card_if on the single clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module gpib_card_link_properties (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// Host bus
	input wire logic       chipSelectN,
	input wire logic       readDataDrive,
	input wire logic       cardDataOeN,
	input wire logic       irqOeN,
	input wire logic       optionPresentN,
	// Instrument side of the card
	input wire logic [7:0] dioOeN,
	input wire logic [7:0] ctlOeN,
	input wire logic       talkerDirectionSelect,
	input wire logic       controllerInCharge
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Fixed transceiver directions (line order: DAV NRFD NDAC EOI ATN SRQ IFC REN)
	// ----------------------------------------
	a_cic_high: assert property (controllerInCharge)
		else $error("controller line not high");
	a_fixed_mgmt: assert property (!ctlOeN[5] && ctlOeN[4] && ctlOeN[6] && ctlOeN[7])
		else $error("fixed management direction wrong");
	a_option_low: assert property (!optionPresentN)
		else $error("option sense not low");

	// ----------------------------------------
	// Talker select steering
	// ----------------------------------------
	a_data_dir: assert property (dioOeN == {8{!talkerDirectionSelect}})
		else $error("data direction disagrees with talker select");
	a_hs_dir: assert property (ctlOeN[0] == !talkerDirectionSelect && ctlOeN[1] == talkerDirectionSelect
		&& ctlOeN[2] == talkerDirectionSelect)
		else $error("handshake direction disagrees with talker select");
	a_eoi_listen: assert property (!talkerDirectionSelect |-> ctlOeN[3])
		else $error("end line driven while listening");

	// ----------------------------------------
	// Host side: read answer and interrupt hold
	// ----------------------------------------
	a_read_answer: assert property ($rose(readDataDrive) && !chipSelectN |=> !cardDataOeN)
		else $error("card did not drive read data");
	a_drive_on_read: assert property (!cardDataOeN |-> $past(readDataDrive))
		else $error("card drove data outside a read");
	// A release with no host access just before it means the line was dropped early
	a_irq_held: assert property ($rose(irqOeN) |-> !$past(chipSelectN, 1) || !$past(chipSelectN, 2)
		|| !$past(chipSelectN, 3))
		else $error("interrupt released without host access");
	// Checked while reset is low, so this one has no disable
	a_talk_reset: assert property (disable iff (1'b0) !resetn |-> !talkerDirectionSelect)
		else $error("talker select high in reset");
endmodule

`default_nettype wire

/* tb_gpib_option_card_interface.sv */
/*
 Testbench: host end and card end joined by gpib_card_if; drives the host
 command port and plays the instrument bus partner.
 Assumes the design files and gpib_card_consts.svh are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpib_card_consts.svh"

module tb_gpib_option_card_interface;
	localparam logic [7:0] ctrlTalk   = 8'h01 << `CTRL_TALK;
	localparam logic [7:0] ctrlSrq    = 8'h01 << `CTRL_SRQ;
	localparam logic [7:0] ctrlRemote = 8'h01 << `CTRL_REMOTE;
	localparam logic [7:0] ctrlIrqEn  = 8'h01 << `CTRL_IRQ_EN;

	logic       clk_sys, resetn, cmdValid, cmdWrite, cmdReady, rspValid, irqPending, cardPresent;
	logic [2:0] cmdAddr;
	logic [7:0] cmdData, rspData, dioIn, dioOut, dioOeN, ctlIn, ctlOut, ctlOeN, rnd;
	logic       talkerDirectionSelect, controllerInCharge, remoteStateOut;
	logic [8:0] notes[$];
	logic [8:0] note;
	int         err_count, comparisons, cycles;
	integer     seed;

	gpib_card_if busIf ();
	gpib_card_host u_gpib_card_host (.clk_sys(clk_sys), .resetn(resetn), .cardBus(busIf),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
		.rspValid(rspValid), .rspData(rspData), .irqPending(irqPending), .cardPresent(cardPresent));
	gpib_card_device u_gpib_card_device (.clk_sys(clk_sys), .resetn(resetn), .hostBus(busIf),
		.dioIn(dioIn), .dioOut(dioOut), .dioOeN(dioOeN), .ctlIn(ctlIn), .ctlOut(ctlOut), .ctlOeN(ctlOeN),
		.talkerDirectionSelect(talkerDirectionSelect), .controllerInCharge(controllerInCharge),
		.remoteStateOut(remoteStateOut));
	gpib_card_link_properties u_gpib_card_link_properties (.clk_sys(clk_sys), .resetn(resetn),
		.chipSelectN(busIf.chipSelectN), .readDataDrive(busIf.readDataDrive), .cardDataOeN(busIf.cardDataOeN),
		.irqOeN(busIf.irqOeN), .optionPresentN(busIf.optionPresentN), .dioOeN(dioOeN), .ctlOeN(ctlOeN),
		.talkerDirectionSelect(talkerDirectionSelect), .controllerInCharge(controllerInCharge));

	// ----------------------------------------
	// Clock, timeout, compare and verdict
	// ----------------------------------------
	always #25 clk_sys = ~clk_sys;

	// Generous ceiling: the whole run needs a few hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Answers come back in command order, so the oldest note belongs to this one
	always @(negedge clk_sys) begin
		if (resetn === 1'b1 && rspValid === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			if (note[8]) begin
				check8(rspData, note[7:0]);
			end
		end
	end

	// ----------------------------------------
	// Host command port driver
	// ----------------------------------------
	task automatic hostCmd(input logic wr, input logic [2:0] a, input logic [7:0] d, input logic [8:0] n);
		@(negedge clk_sys);
		cmdValid = 1'b1;
		cmdWrite = wr;
		cmdAddr  = a;
		cmdData  = d;
		notes.push_back(n);
		while (cmdReady !== 1'b1) @(negedge clk_sys);
		@(negedge clk_sys);
		cmdValid = 1'b0;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		hostCmd(1'b1, a, d, 9'h000);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		hostCmd(1'b0, a, 8'h00, {1'b1, exp});
	endtask

	task automatic drain();
		while (notes.size() != 0) @(negedge clk_sys);
		@(negedge clk_sys);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		seed = 32'he9880074;
		clk_sys = 1'b0;
		resetn = 1'b1;
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdAddr = 3'h0;
		cmdData = 8'h00;
		dioIn = 8'hff;
		ctlIn = 8'hff;
		// Reset falls just after time zero so every reset branch sees an edge
		#1;
		resetn = 1'b0;
		repeat (8) @(negedge clk_sys);
		resetn = 1'b1;
		@(negedge clk_sys iff (cmdReady === 1'b1));
		check8({7'h0, cardPresent}, 8'h01);

		// Register select: stored poll byte, unused offsets ignore writes
		rnd = 8'($random(seed));
		wr(`REG_POLL, rnd);
		for (int a = 4; a < 8; a++) wr(3'(a), 8'hff);
		rd(`REG_POLL, rnd);
		for (int a = 4; a < 8; a++) rd(3'(a), 8'h00);
		wr(`REG_CTRL_STAT, ctrlRemote);
		rd(`REG_CTRL_STAT, 8'h01 << `STAT_REMOTE);
		drain();
		check8({7'h0, remoteStateOut}, 8'h01);
		$display("test registers done");

		// Listener: one byte in, interrupt held until the byte is read
		wr(`REG_CTRL_STAT, ctrlIrqEn);
		drain();
		rnd = 8'($random(seed));
		dioIn = ~rnd;
		ctlIn = ~(8'h01 << `LN_DAV);
		@(negedge clk_sys iff (irqPending === 1'b1));
		check8({7'h0, ctlOut[`LN_NDAC]}, 8'h01);
		ctlIn = 8'hff;
		dioIn = 8'hff;
		repeat (40) @(negedge clk_sys);
		check8({7'h0, irqPending}, 8'h01);
		rd(`REG_DATA, rnd);
		drain();
		repeat (4) @(negedge clk_sys);
		check8({7'h0, irqPending}, 8'h00);
		$display("test listener done");

		// Talker: line feed with end flag, listener holds NDAC until accepted
		ctlIn = ~(8'h01 << `LN_NDAC);
		wr(`REG_CTRL_STAT, ctrlTalk | ctrlIrqEn);
		wr(`REG_AUX, 8'h01);
		wr(`REG_DATA, 8'h0a);
		drain();
		check8({7'h0, talkerDirectionSelect}, 8'h01);
		@(negedge clk_sys iff (ctlOut[`LN_DAV] === 1'b0));
		check8(dioOut, ~8'h0a);
		check8({6'h0, ctlOut[`LN_EOI], ctlOeN[`LN_EOI]}, 8'h00);
		ctlIn = 8'hff;
		@(negedge clk_sys iff (irqPending === 1'b1));
		check8({7'h0, ctlOut[`LN_DAV]}, 8'h01);
		rd(`REG_AUX, 8'h00);
		wr(`REG_CTRL_STAT, 8'h00);
		drain();
		repeat (4) @(negedge clk_sys);
		check8({7'h0, irqPending}, 8'h00);
		$display("test talker done");

		// Service request, dropped by the poll command sent under ATN
		wr(`REG_CTRL_STAT, ctrlSrq);
		drain();
		repeat (4) @(negedge clk_sys);
		check8({7'h0, ctlOut[`LN_SRQ]}, 8'h00);
		dioIn = ~`CMD_POLL_ENABLE;
		ctlIn = ~((8'h01 << `LN_DAV) | (8'h01 << `LN_ATN));
		@(negedge clk_sys iff (ctlOut[`LN_SRQ] === 1'b1));
		check8({7'h0, irqPending}, 8'h00);
		ctlIn = 8'hff;
		dioIn = 8'hff;
		// Command byte leaves the receive flag clear; only the old send flag stays
		rd(`REG_CTRL_STAT, 8'h01 << `STAT_TX_DONE);
		$display("test service request done");

		// Bus reset drops the talk address, then reset in mid run while addressed to talk
		wr(`REG_CTRL_STAT, ctrlTalk);
		drain();
		ctlIn = ~(8'h01 << `LN_IFC);
		repeat (4) @(negedge clk_sys);
		check8({7'h0, talkerDirectionSelect}, 8'h00);
		ctlIn = 8'hff;
		wr(`REG_CTRL_STAT, ctrlTalk);
		drain();
		check8({7'h0, talkerDirectionSelect}, 8'h01);
		resetn = 1'b0;
		@(negedge clk_sys);
		check8({7'h0, talkerDirectionSelect}, 8'h00);
		check8(dioOeN, 8'hff);
		resetn = 1'b1;
		@(negedge clk_sys iff (cmdReady === 1'b1));
		rd(`REG_CTRL_STAT, 8'h00);
		drain();
		$display("test reset done");
		wrap_up();
	end
endmodule

`default_nettype wire
